/* File: timer_irq_pkg.sv */
`default_nettype none
package timer_irq_pkg;
    // ==========================================================
    // Register map, byte addresses on the AXI4-Lite bus.
    // ==========================================================
    localparam logic [31:0] ADDR_ENABLE_CLEAR = 32'h0000_0000;
    localparam logic [31:0] ADDR_ENABLE_SET = 32'h0000_0004;
    localparam logic [31:0] ADDR_FLAG = 32'h0000_0008;
    localparam logic [31:0] ADDR_EVENT_CTRL = 32'h0000_000C;
    localparam logic [31:0] ADDR_PENDING = 32'h0000_0010;
    localparam logic [31:0] ADDR_WORD_MASK = 32'h0000_00FC;

    // ==========================================================
    // Reset values and field masks.
    // ==========================================================
    localparam logic [31:0] SRC_IMPL_MASK = 32'h000F_F80F;
    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam int EVCTRL_OVF_EVENT_BIT = 0;
    localparam logic [31:0] EVCTRL_IMPL_MASK = 32'h0000_0001;

    // ==========================================================
    // AXI response codes.
    // ==========================================================
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // One bit per interrupt source; reserved holes read as zero.
    typedef struct packed {
        logic [11:0] rsv_hi;            // Bits 31:20, reserved.
        logic [3:0] match_capture_channel; // Bits 19:16.
        logic [1:0] nonrecoverable_fault; // Bits 15:14.
        logic [1:0] recoverable_fault;  // Bits 13:12.
        logic debug_fault_state;        // Bit 11.
        logic [6:0] rsv_lo;             // Bits 10:4, reserved.
        logic capture_overflow_error;   // Bit 3.
        logic count_event_irq;          // Bit 2.
        logic retrigger;                // Bit 1.
        logic overflow_underflow;       // Bit 0.
    } irq_src_t;

    // One register write handed from the bus slave to the core.
    typedef struct packed {
        logic valid;          // One-cycle write strobe.
        logic [31:0] addr;    // Byte address as taken from the bus, not aligned.
        logic [31:0] data;    // Write data.
        logic [3:0] strb;     // Byte lane enables.
    } wr_req_t;

    // True when the address hits one of the mapped words.
    function automatic logic addr_mapped(input logic [31:0] addr);
        logic [31:0] a;
        a = addr & ADDR_WORD_MASK;
        addr_mapped = (addr[31:8] == 24'h00_0000) &&
            (a == ADDR_ENABLE_CLEAR || a == ADDR_ENABLE_SET ||
             a == ADDR_FLAG || a == ADDR_EVENT_CTRL || a == ADDR_PENDING);
    endfunction
endpackage
`default_nettype wire

/* File: axil_reg_port.sv */
`default_nettype none
module axil_reg_port
    import timer_irq_pkg::*;
(
    input wire logic aclk,              // System clock.
    input wire logic aresetn,           // Synchronous reset, low.
    input wire logic [31:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid,     // Write address valid.
    output logic s_axi_awready,         // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write byte enables.
    input wire logic s_axi_wvalid,      // Write data valid.
    output logic s_axi_wready,          // Write data ready.
    output logic [1:0] s_axi_bresp,     // Write response.
    output logic s_axi_bvalid,          // Write response valid.
    input wire logic s_axi_bready,      // Write response ready.
    input wire logic [31:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid,     // Read address valid.
    output logic s_axi_arready,         // Read address ready.
    output logic [31:0] s_axi_rdata,    // Read data.
    output logic [1:0] s_axi_rresp,     // Read response.
    output logic s_axi_rvalid,          // Read data valid.
    input wire logic s_axi_rready,      // Read data ready.
    output wr_req_t wr_req,             // Write strobe to the core.
    output logic [31:0] rd_addr,        // Address being read.
    input wire logic [31:0] rd_data     // Core read data for rd_addr.
);
    // ==========================================================
    // Write channel.
    // ==========================================================
    // Address and data are caught in either order; the write fires once both are held.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            wr_req <= '0;
        end else begin
            wr_req.valid <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                wr_req.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wr_req.data <= s_axi_wdata;
                wr_req.strb <= s_axi_wstrb;
            end
            if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid && !wr_req.valid) begin
                wr_req.valid <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_mapped(wr_req.addr) ? RESP_OKAY : RESP_DECERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read channel.
    // ==========================================================
    // The address is held one cycle so the core mux settles, then the data is registered.
    logic rd_pend; // Address taken, data not yet captured.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= RESET_ZERO;
            s_axi_rresp <= RESP_OKAY;
            rd_addr <= RESET_ZERO;
            rd_pend <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                rd_addr <= s_axi_araddr;
                rd_pend <= 1'b1;
            end
            if (rd_pend) begin
                rd_pend <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data;
                s_axi_rresp <= addr_mapped(rd_addr) ? RESP_OKAY : RESP_DECERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: timer_irq_flag_logic.sv */
// What this block does
// - Flags for overflow, retrigger, count, faults, channels.
// - Every source also raises a wake-up request.
// - A source event sets its flag regardless of enable.
// - Writing one to enable-set enables that source.
// - Writing one to enable-clear disables that source.
// - Request high when flag and enable both set.
// - Request holds until flag, enable or reset clear.
// - All sources share one request output.
// - Overflow also drives an output event.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`default_nettype none
module timer_irq_flag_logic
    import timer_irq_pkg::*;
(
    input wire logic aclk,              // System clock, 250 MHz.
    input wire logic aresetn,           // Synchronous reset, low.
    input wire logic [31:0] s_axi_awaddr, // AXI write address.
    input wire logic s_axi_awvalid,     // AXI write address valid.
    output logic s_axi_awready,         // AXI write address ready.
    input wire logic [31:0] s_axi_wdata, // AXI write data.
    input wire logic [3:0] s_axi_wstrb, // AXI write byte enables.
    input wire logic s_axi_wvalid,      // AXI write data valid.
    output logic s_axi_wready,          // AXI write data ready.
    output logic [1:0] s_axi_bresp,     // AXI write response.
    output logic s_axi_bvalid,          // AXI write response valid.
    input wire logic s_axi_bready,      // AXI write response ready.
    input wire logic [31:0] s_axi_araddr, // AXI read address.
    input wire logic s_axi_arvalid,     // AXI read address valid.
    output logic s_axi_arready,         // AXI read address ready.
    output logic [31:0] s_axi_rdata,    // AXI read data.
    output logic [1:0] s_axi_rresp,     // AXI read response.
    output logic s_axi_rvalid,          // AXI read data valid.
    input wire logic s_axi_rready,      // AXI read data ready.
    input wire irq_src_t src_events,    // Condition pulses from the timer.
    output logic irq,                   // Shared interrupt request, high.
    output logic wake_request,          // Wake-up pulse toward power control.
    output logic overflow_event         // Overflow output event pulse.
);
    // ==========================================================
    // Local state.
    // ==========================================================
    wr_req_t wr_req;            // Write strobe from the bus slave.
    logic [31:0] rd_addr;       // Address the slave is reading.
    logic [31:0] rd_data;       // Read mux result for rd_addr.
    irq_src_t flag;             // Sticky interrupt flags.
    irq_src_t enable;           // Interrupt enable mask.
    logic [31:0] event_ctrl;    // Output event control bits.
    irq_src_t next_flag;        // Flag value after this edge.
    irq_src_t next_enable;      // Enable value after this edge.
    logic [31:0] lane_bits;     // Write data with disabled lanes zeroed.
    logic wr_flag;              // This write targets the flag register.
    logic wr_en_set;            // This write targets enable-set.
    logic wr_en_clr;            // This write targets enable-clear.
    logic wr_evctrl;            // This write targets event control.
    irq_src_t src_valid;        // Source pulses with reserved bits removed.

    // ==========================================================
    // Helper functions.
    // ==========================================================
    // Byte enables as a bit mask, so a narrow write touches only its lanes.
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = RESET_ZERO;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        lane_mask = m;
    endfunction

    // Compares the aligned part of an address with a register offset.
    function automatic logic hits(input logic [31:0] addr, input logic [31:0] off);
        hits = addr_mapped(addr) && ((addr & ADDR_WORD_MASK) == off);
    endfunction

    // ==========================================================
    // Bus slave.
    // ==========================================================
    // The slave owns the handshakes and hands over one write strobe per transfer.
    axil_reg_port u_port (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .wr_req(wr_req), .rd_addr(rd_addr), .rd_data(rd_data)
    );

    // ==========================================================
    // Write decode.
    // ==========================================================
    // Selecting only on the one-cycle strobe means a held address never writes twice.
    always_comb begin
        lane_bits = wr_req.data & lane_mask(wr_req.strb);
        wr_flag = wr_req.valid && hits(wr_req.addr, ADDR_FLAG);
        wr_en_set = wr_req.valid && hits(wr_req.addr, ADDR_ENABLE_SET);
        wr_en_clr = wr_req.valid && hits(wr_req.addr, ADDR_ENABLE_CLEAR);
        wr_evctrl = wr_req.valid && hits(wr_req.addr, ADDR_EVENT_CTRL);
    end

    // Reserved source positions never reach a flag.
    assign src_valid = irq_src_t'(src_events & SRC_IMPL_MASK);

    // ==========================================================
    // Next flag and enable values.
    // ==========================================================
    // The event term is ORed in after the clear, so an event in the
    // clearing cycle keeps its flag and the interrupt is not lost.
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi++) begin : g_bit
            if (SRC_IMPL_MASK[gi]) begin : g_impl
                always_comb begin
                    // Write one clears; write zero leaves the flag alone.
                    next_flag[gi] = flag[gi] & ~(wr_flag & lane_bits[gi]);
                    // A condition sets the flag whether enabled or not.
                    next_flag[gi] = next_flag[gi] | src_valid[gi];
                    next_enable[gi] = enable[gi];
                    if (wr_en_set && lane_bits[gi]) begin
                        next_enable[gi] = 1'b1;
                    end else if (wr_en_clr && lane_bits[gi]) begin
                        next_enable[gi] = 1'b0;
                    end
                end
            end else begin : g_rsv
                // Reserved bits are tied low so they read as zero.
                always_comb begin
                    next_flag[gi] = 1'b0;
                    next_enable[gi] = 1'b0;
                end
            end
        end
    endgenerate

    // ==========================================================
    // Flag register.
    // ==========================================================
    // Sticky until software writes one; reset clears everything.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag <= irq_src_t'(RESET_ZERO);
        end else begin
            flag <= next_flag;
        end
    end

    // ==========================================================
    // Enable mask register.
    // ==========================================================
    // Separate set and clear words avoid a read-modify-write race.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable <= irq_src_t'(RESET_ZERO);
        end else begin
            enable <= next_enable;
        end
    end

    // ==========================================================
    // Event control register.
    // ==========================================================
    // Only the overflow event enable exists; other bits read as zero.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_ctrl <= RESET_ZERO;
        end else if (wr_evctrl) begin
            event_ctrl <= (event_ctrl & ~lane_mask(wr_req.strb))
                | (lane_bits & EVCTRL_IMPL_MASK);
        end
    end

    // ==========================================================
    // Shared interrupt request.
    // ==========================================================
    // Built from the next values, so the request moves with the flags, no lag.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            // One line for all sources, high while any enabled flag is set.
            irq <= |(next_flag & next_enable);
        end
    end

    // ==========================================================
    // Wake-up request.
    // ==========================================================
    // Any source may wake the system, enabled or not; being registered,
    // the pulse lags the condition by one edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= |src_valid;
        end
    end

    // ==========================================================
    // Overflow output event.
    // ==========================================================
    // One-cycle pulse per overflow, independent of the flag and its clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overflow_event <= 1'b0;
        end else begin
            overflow_event <= src_valid.overflow_underflow
                & event_ctrl[EVCTRL_OVF_EVENT_BIT];
        end
    end

    // ==========================================================
    // Read mux.
    // ==========================================================
    // Reads have no side effect, so software may poll the flags freely.
    always_comb begin
        rd_data = RESET_ZERO;
        if (hits(rd_addr, ADDR_FLAG)) begin
            // Software scans this word to find the causes.
            rd_data = flag;
        end else if (hits(rd_addr, ADDR_ENABLE_SET) || hits(rd_addr, ADDR_ENABLE_CLEAR)) begin
            rd_data = enable;
        end else if (hits(rd_addr, ADDR_EVENT_CTRL)) begin
            rd_data = event_ctrl;
        end else if (hits(rd_addr, ADDR_PENDING)) begin
            // Flags that are currently driving the request.
            rd_data = flag & enable;
        end else begin
            // Unmapped words read as zero with a decode error.
            rd_data = RESET_ZERO;
        end
    end
endmodule
`default_nettype wire

/* File: irq_sink_model.sv */
`default_nettype none
// ============================================================
// Interrupt controller and event system stand-in.
// ============================================================
module irq_sink_model (
    input wire logic aclk,           // System clock.
    input wire logic aresetn,        // Synchronous reset, low.
    input wire logic irq,            // Shared request line.
    input wire logic overflow_event, // Event pulse input.
    input wire logic wake_request,   // Wake pulse input.
    output logic [7:0] event_count,  // Event pulses seen.
    output logic [7:0] irq_count     // Request rises seen.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic irq_seen; // Last request level, for edge detection.

    // Events are single-cycle pulses, so each high cycle is one event.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_count <= 8'h00;
        end else if (overflow_event) begin
            event_count <= event_count + 8'h01;
        end
    end

    // One shared line is all the controller listens to.
    always_ff @(posedge aclk) begin
        irq_seen <= aresetn && irq;
        if (!aresetn) begin
            irq_count <= 8'h00;
        end else if (irq && !irq_seen) begin
            irq_count <= irq_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: timer_irq_checker_assertions.sv */
`default_nettype none
// ============================================================
// Port-level checker for the flag and request logic.
// ============================================================
module timer_irq_checker
    import timer_irq_pkg::*;
(
    input wire logic aclk,           // System clock.
    input wire logic aresetn,        // Synchronous reset, low.
    input wire logic s_axi_awready,  // Write address ready.
    input wire logic s_axi_wready,   // Write data ready.
    input wire logic [1:0] s_axi_bresp, // Write response.
    input wire logic s_axi_bvalid,   // Write response valid.
    input wire logic s_axi_bready,   // Write response ready.
    input wire logic s_axi_arvalid,  // Read address valid.
    input wire logic s_axi_arready,  // Read address ready.
    input wire logic s_axi_rvalid,   // Read data valid.
    input wire logic s_axi_rready,   // Read data ready.
    input wire irq_src_t src_events, // Source pulses.
    input wire logic irq,            // Shared request.
    input wire logic wake_request,   // Wake pulse.
    input wire logic overflow_event  // Event pulse.
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Only a source pulse or a finished write can move the request line.
    a_wake_follows: assert property (|(src_events & SRC_IMPL_MASK) |=> wake_request)
        else $error("wake missing after source pulse");
    a_wake_quiet: assert property (!(|(src_events & SRC_IMPL_MASK)) |=> !wake_request)
        else $error("wake without source pulse");
    a_event_cause: assert property (overflow_event |-> $past(src_events.overflow_underflow))
        else $error("overflow event without overflow");
    a_irq_rise: assert property ($rose(irq) |-> $past(|(src_events & SRC_IMPL_MASK))
        || $past(s_axi_bvalid)) else $error("request rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(s_axi_bvalid))
        else $error("request fell without a write");
    a_b_after_data: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
        else $error("write response before both channels taken");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_r_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
        else $error("read answer late");
    c_irq_rise: cover property ($rose(irq));
    c_event: cover property (overflow_event);
    c_decerr: cover property (s_axi_bvalid && s_axi_bresp == RESP_DECERR);
endmodule
bind timer_irq_flag_logic timer_irq_checker u_timer_irq_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .src_events(src_events), .irq(irq),
    .wake_request(wake_request), .overflow_event(overflow_event));
`default_nettype wire

/* File: timer_irq_flag_logic_bench.sv */
`default_nettype none
// ============================================================
// Register-level tests of the flag and request logic.
// ============================================================
module timer_irq_flag_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import timer_irq_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, irq, wake_request, overflow_event;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
    logic [3:0] s_axi_wstrb; // Full-word writes only.
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] event_count, irq_count;
    irq_src_t src_events; // Driven by the bench in the timer's place.
    int n_fail = 0, n_checks = 0;

    timer_irq_flag_logic u_timer_irq_flag_logic (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .src_events(src_events),
        .irq(irq), .wake_request(wake_request), .overflow_event(overflow_event));
    irq_sink_model u_irq_sink_model (.aclk(aclk), .aresetn(aresetn), .irq(irq),
        .overflow_event(overflow_event), .wake_request(wake_request),
        .event_count(event_count), .irq_count(irq_count));

    // 250 MHz clock.
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic results();
        if (n_fail == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Handshakes are judged at the falling edge; ev lands on the edge that applies the write.
    task automatic wr(input logic [31:0] a, d, input logic [1:0] er, input logic [31:0] ev);
        logic aw, w, b = 1'b0;
        logic [1:0] resp;
        int n = 0, k = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b && n < 50) begin
            @(negedge aclk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid && s_axi_bready;
            resp = s_axi_bresp;
            n++;
            @(posedge aclk);
            if (aw || k > 0) k++;
            if (k == 2) src_events <= ev;
            if (k == 3) src_events <= '0;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (b) s_axi_bready <= 1'b0;
        end
        @(negedge aclk);
        chk({30'h0, resp}, {30'h0, er});
    endtask

    task automatic rd(input logic [31:0] a, exp, input logic [1:0] er);
        logic ar, r = 1'b0;
        logic [31:0] d;
        logic [1:0] rr;
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r && n < 50) begin
            @(negedge aclk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            rr = s_axi_rresp;
            n++;
            @(posedge aclk);
            if (ar) s_axi_arvalid <= 1'b0;
            if (r) s_axi_rready <= 1'b0;
        end
        chk(d, exp);
        chk({30'h0, rr}, {30'h0, er});
    endtask

    // One-cycle source pulse, then wait for the registered outputs to land.
    task automatic pulse(input logic [31:0] v);
        @(posedge aclk);
        src_events <= v;
        @(posedge aclk);
        src_events <= '0;
        repeat (2) @(negedge aclk);
    endtask

    // A hang anywhere ends the run as a failure.
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        results();
    end

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        src_events = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(ADDR_FLAG, RESET_ZERO, RESP_OKAY);
        rd(ADDR_ENABLE_SET, RESET_ZERO, RESP_OKAY);
        rd(ADDR_EVENT_CTRL, RESET_ZERO, RESP_OKAY);
        wr(ADDR_ENABLE_SET, 32'h5, RESP_OKAY, '0);
        wr(ADDR_ENABLE_SET, 32'h0, RESP_OKAY, '0);
        rd(ADDR_ENABLE_CLEAR, 32'h5, RESP_OKAY);
        wr(ADDR_ENABLE_CLEAR, 32'h1, RESP_OKAY, '0);
        wr(ADDR_ENABLE_CLEAR, 32'h0, RESP_OKAY, '0);
        rd(ADDR_ENABLE_SET, 32'h4, RESP_OKAY);
        pulse(32'h2);
        chk({31'h0, irq}, 32'h0);
        pulse(32'hFFFF_FFFF);
        chk({31'h0, irq}, 32'h1);
        rd(ADDR_FLAG, SRC_IMPL_MASK, RESP_OKAY);
        rd(ADDR_PENDING, 32'h4, RESP_OKAY);
        wr(ADDR_FLAG, 32'h4, RESP_OKAY, '0);
        chk({31'h0, irq}, 32'h0);
        rd(ADDR_FLAG, SRC_IMPL_MASK & ~32'h4, RESP_OKAY);
        wr(ADDR_ENABLE_SET, 32'h1000, RESP_OKAY, '0);
        chk({31'h0, irq}, 32'h1);
        wr(ADDR_ENABLE_CLEAR, 32'h1000, RESP_OKAY, '0);
        chk({31'h0, irq}, 32'h0);
        chk({24'h0, irq_count}, 32'h2);
        wr(ADDR_FLAG, 32'hFFFF_FFFF, RESP_OKAY, '0);
        rd(ADDR_FLAG, RESET_ZERO, RESP_OKAY);
        pulse(32'h2);
        wr(ADDR_FLAG, 32'h2, RESP_OKAY, 32'h2);
        rd(ADDR_FLAG, 32'h2, RESP_OKAY);
        wr(ADDR_EVENT_CTRL, 32'h1, RESP_OKAY, '0);
        rd(ADDR_EVENT_CTRL, 32'h1, RESP_OKAY);
        pulse(32'h1);
        chk({24'h0, event_count}, 32'h1);
        wr(ADDR_EVENT_CTRL, 32'h0, RESP_OKAY, '0);
        pulse(32'h1);
        chk({24'h0, event_count}, 32'h1);
        wr(32'h100, 32'hFFFF_FFFF, RESP_DECERR, '0);
        rd(32'h20, RESET_ZERO, RESP_DECERR);
        rd(ADDR_FLAG, 32'h3, RESP_OKAY);
        results();
    end
endmodule
`default_nettype wire
